//--- logic/hka_adc_regs.svh
`ifndef HKA_ADC_REGS_SVH
`define HKA_ADC_REGS_SVH

// Register byte offsets, one 32-bit word each
`define HKA_OFF_CTRL1 8'h00
`define HKA_OFF_RT_CTRL 8'h04
`define HKA_OFF_SINGLE_SEL 8'h08
`define HKA_OFF_SINGLE_LOW 8'h0c
`define HKA_OFF_SINGLE_HIGH 8'h10
`define HKA_OFF_PER_SEL 8'h14
`define HKA_OFF_THR0_LOW 8'h18
`define HKA_OFF_THR0_HIGH 8'h1c
`define HKA_OFF_THR1_LOW 8'h20
`define HKA_OFF_THR1_HIGH 8'h24
`define HKA_OFF_PER_CTRL 8'h28
`define HKA_OFF_RES0_LOW 8'h2c
`define HKA_OFF_RES0_HIGH 8'h30
`define HKA_OFF_RES1_LOW 8'h34
`define HKA_OFF_RES1_HIGH 8'h38
`define HKA_OFF_STATUS 8'h3c
`define HKA_OFF_TRIM1 8'h40
`define HKA_OFF_TRIM2 8'h44

// Field positions
`define HKA_CTRL1_FORCE_BIT 0
`define HKA_CTRL1_BIAS_LSB 1
`define HKA_RT_EXTEND_BIT 0
`define HKA_SEL_START_BIT 7
`define HKA_THR_POL_BIT 7
`define HKA_PCTRL_EN0_BIT 0
`define HKA_PCTRL_EN1_BIT 1
`define HKA_PCTRL_IVL_LSB 2
`define HKA_PCTRL_SD0_BIT 5
`define HKA_PCTRL_SD1_BIT 6

// Reset values
`define HKA_RST_BYTE 8'h00

// Timing and code range
`define HKA_CLK_MHZ 20
`define HKA_EXT_DELAY_US 400
`define HKA_SETTLE_NS 1000
`define HKA_INTERVAL_BASE_US 1000
`define HKA_CODE_MAX 12'hfff

`endif

//--- logic/hka_adc_pkg.sv
package hka_adc_pkg;
	typedef enum logic [1:0] {
		HKA_PS_ACTIVE,
		HKA_PS_SLEEP,
		HKA_PS_OFF
	} hka_power_state_t;

	typedef enum {
		HKA_ST_IDLE,
		HKA_ST_SETTLE,
		HKA_ST_CONVERT
	} hka_state_t;

	// Toward the analog converter and input mux
	typedef struct packed {
		logic power_on;
		logic reference_on;
		logic sample;
		logic [3:0] channel;
		logic [1:0] bias_sel;
	} hka_conv_ctrl_t;

	// Back from the converter core
	typedef struct packed {
		logic done;
		logic [11:0] code;
	} hka_conv_stat_t;
endpackage : hka_adc_pkg

//--- logic/hka_adc_sequencer.sv
`timescale 1ns/100ps
`include "hka_adc_regs.svh"

// Functional notes
// - Result codes are 12-bit unsigned, range bottom 0 and top 4095.
// - Sixteen mux channels, nine usable: three external, six internal.
// - Every finished conversion raises an event toward the host.
// - Pending single conversion wins over pending periodic conversion.
// - Extended-delay bit adds 400 us between selection and sampling.
// - Host picks channel, then starts; result lands in single registers.
// - External input zero bias current selectable: 0, 5, 15, 20 uA.
// - Periodic conversions run at chosen interval per enabled slot.
// - Periodic mode powers converter up per conversion, then down.
// - Latest periodic results go to result registers; with both slots on, by channel order.
// - Periodic queue converts ascending; lower channel result in slot 0.
// - Threshold crossing stores result and raises the converter event.
// - Periodic runs on despite unread results; new results overwrite.
// - Threshold crossing requests shutdown when slot shutdown enabled.
// - Sleep/off: channels 0 to 10; 12, 13 in sleep with thermal on.
// - Reference output driven whenever converter is enabled.
module hka_adc_sequencer #(
	parameter int unsigned EXT_DELAY_CYC = `HKA_EXT_DELAY_US * `HKA_CLK_MHZ,
	parameter int unsigned INTERVAL_BASE_CYC =
		`HKA_INTERVAL_BASE_US * `HKA_CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output hka_adc_pkg::hka_conv_ctrl_t conv_ctrl,
	input wire hka_adc_pkg::hka_conv_stat_t conv_stat,
	input wire hka_adc_pkg::hka_power_state_t power_state,
	input wire logic thermal_sensor_en,
	input wire logic [7:0] factory_deviation_one,
	input wire logic [7:0] factory_deviation_two,
	output logic conv_event,
	output logic threshold_event,
	output logic shutdown_req
);
	import hka_adc_pkg::*;

	localparam int unsigned SETTLE_CYC_RAW =
		(`HKA_SETTLE_NS * `HKA_CLK_MHZ + 999) / 1000;
	localparam int unsigned SETTLE_CYC =
		(SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

	// Channel usable at all, and usable in the present power state
	function automatic logic chan_usable(input logic [3:0] ch);
		chan_usable = (ch <= 4'h2) || (ch == 4'h7) || (ch >= 4'ha &&
			ch <= 4'hd) || (ch == 4'hf);
	endfunction : chan_usable

	function automatic logic chan_allowed(input logic [3:0] ch,
		input hka_power_state_t ps, input logic therm);
		logic low_ok;
		logic die_ok;
		low_ok = ch <= 4'ha;
		die_ok = (ch == 4'hc || ch == 4'hd) && ps == HKA_PS_SLEEP && therm;
		chan_allowed = chan_usable(ch) &&
			(ps == HKA_PS_ACTIVE || low_ok || die_ok);
	endfunction : chan_allowed

	logic rst_meta;
	logic rst_sync;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Software-visible storage
	logic [7:0] ctrl1;
	logic [7:0] rt_ctrl;
	logic [3:0] single_chan;
	logic [11:0] single_result;
	logic [7:0] per_sel;
	logic [7:0] thr_low [2];
	logic [7:0] thr_high [2];
	logic [7:0] per_ctrl;
	logic [11:0] slot_result [2];

	// Sequencer state
	hka_state_t state;
	hka_state_t next_state;
	logic sw_pend;
	logic [1:0] per_pend;
	logic cur_is_sw;
	logic cur_dest;
	logic [3:0] cur_chan;
	logic [23:0] delay_cnt;
	logic [23:0] ivl_cnt;
	logic first_done;

	// Bus decode
	wire bus_req = cyc_i && stb_i && !ack_o;
	wire bus_wr = bus_req && we_i && sel_i[0];
	wire hit_ctrl1 = adr_i == `HKA_OFF_CTRL1;
	wire hit_rt = adr_i == `HKA_OFF_RT_CTRL;
	wire hit_ssel = adr_i == `HKA_OFF_SINGLE_SEL;
	wire hit_psel = adr_i == `HKA_OFF_PER_SEL;
	wire hit_pctrl = adr_i == `HKA_OFF_PER_CTRL;
	wire [1:0] hit_thr_low = {adr_i == `HKA_OFF_THR1_LOW,
		adr_i == `HKA_OFF_THR0_LOW};
	wire [1:0] hit_thr_high = {adr_i == `HKA_OFF_THR1_HIGH,
		adr_i == `HKA_OFF_THR0_HIGH};
	wire sw_start = bus_wr && hit_ssel && dat_i[`HKA_SEL_START_BIT];

	// Field views
	wire force_on = ctrl1[`HKA_CTRL1_FORCE_BIT];
	wire [1:0] bias_sel = ctrl1[`HKA_CTRL1_BIAS_LSB +: 2];
	wire extend_delay = rt_ctrl[`HKA_RT_EXTEND_BIT];
	wire [3:0] slot_chan [2];
	assign slot_chan[0] = per_sel[3:0];
	assign slot_chan[1] = per_sel[7:4];
	wire [1:0] slot_en = {per_ctrl[`HKA_PCTRL_EN1_BIT],
		per_ctrl[`HKA_PCTRL_EN0_BIT]};
	wire [1:0] slot_sd = {per_ctrl[`HKA_PCTRL_SD1_BIT],
		per_ctrl[`HKA_PCTRL_SD0_BIT]};
	wire [2:0] ivl_sel = per_ctrl[`HKA_PCTRL_IVL_LSB +: 3];

	// Interval timer: base period doubled per select step
	wire [23:0] ivl_limit = 24'(INTERVAL_BASE_CYC) << ivl_sel;
	wire ivl_tick = (slot_en != 2'b00) && ivl_cnt >= ivl_limit - 24'h1;
	wire [23:0] next_ivl_cnt = (slot_en == 2'b00 || ivl_tick) ? 24'h0 :
		ivl_cnt + 24'h1;

	// Arbitration in idle
	wire idle = state == HKA_ST_IDLE;
	wire both_pend = per_pend == 2'b11;
	wire pick_slot = both_pend ? (slot_chan[1] < slot_chan[0]) :
		per_pend[1];
	wire take_sw = idle && sw_pend;
	wire take_per = idle && !sw_pend && per_pend != 2'b00;
	wire [3:0] take_chan = take_sw ? single_chan : slot_chan[pick_slot];
	wire take_ok = chan_allowed(take_chan, power_state, thermal_sensor_en);
	// Both slots on: first in ascending order lands in slot 0
	wire both_en = slot_en == 2'b11;
	wire lower_first = slot_chan[pick_slot] <= slot_chan[~pick_slot];
	wire take_dest = both_en ? !lower_first : pick_slot;
	wire [1:0] per_take = {take_per && pick_slot, take_per && !pick_slot};
	// Tick while a round is still queued is dropped: a slow conversion
	// must not let the lower channel starve the higher one
	wire [1:0] per_left = per_pend & ~per_take;

	wire [23:0] settle_load = 24'(SETTLE_CYC) +
		(extend_delay ? 24'(EXT_DELAY_CYC) : 24'h0);
	wire settle_end = state == HKA_ST_SETTLE && delay_cnt == 24'h1;
	wire conv_end = state == HKA_ST_CONVERT && conv_stat.done;

	// Threshold check against destination slot
	wire [11:0] dest_thr = {thr_high[cur_dest][3:0], thr_low[cur_dest]};
	wire dest_pol = thr_high[cur_dest][`HKA_THR_POL_BIT];
	wire crossed = dest_pol ? (conv_stat.code > dest_thr) :
		(conv_stat.code < dest_thr);
	wire per_end = conv_end && !cur_is_sw;
	wire per_hit = per_end && crossed;

	always_comb begin
		next_state = state;
		case (state)
			HKA_ST_IDLE: begin
				if ((take_sw || take_per) && take_ok) begin
					next_state = HKA_ST_SETTLE;
				end
			end
			HKA_ST_SETTLE: begin
				if (settle_end) begin
					next_state = HKA_ST_CONVERT;
				end
			end
			HKA_ST_CONVERT: begin
				if (conv_end) begin
					next_state = HKA_ST_IDLE;
				end
			end
			default: begin
				next_state = HKA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= HKA_ST_IDLE;
			delay_cnt <= 24'h0;
			cur_is_sw <= 1'b0;
			cur_dest <= 1'b0;
			cur_chan <= 4'h0;
		end else begin
			state <= next_state;
			if ((take_sw || take_per) && take_ok) begin
				delay_cnt <= settle_load;
				cur_is_sw <= take_sw;
				cur_dest <= take_dest;
				cur_chan <= take_chan;
			end else if (state == HKA_ST_SETTLE) begin
				delay_cnt <= delay_cnt - 24'h1;
			end
		end
	end

	// Pending flags: a new request in the taking cycle survives
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			sw_pend <= 1'b0;
			per_pend <= 2'b00;
			ivl_cnt <= 24'h0;
		end else begin
			sw_pend <= sw_start || (sw_pend && !take_sw);
			per_pend <= (ivl_tick && per_left == 2'b00) ? slot_en :
				per_left & slot_en;
			ivl_cnt <= next_ivl_cnt;
		end
	end

	// Converter drive and event pulses
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			conv_ctrl <= '0;
			conv_event <= 1'b0;
			threshold_event <= 1'b0;
			shutdown_req <= 1'b0;
		end else begin
			conv_ctrl.power_on <= next_state != HKA_ST_IDLE ||
				force_on;
			conv_ctrl.reference_on <= next_state != HKA_ST_IDLE ||
				force_on;
			conv_ctrl.sample <= settle_end;
			conv_ctrl.channel <= (take_sw || take_per) ? take_chan :
				cur_chan;
			conv_ctrl.bias_sel <= bias_sel;
			conv_event <= conv_end;
			threshold_event <= per_hit;
			shutdown_req <= per_hit && slot_sd[cur_dest];
		end
	end

	// Result storage; unread results are simply overwritten
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			single_result <= 12'h0;
			slot_result[0] <= 12'h0;
			slot_result[1] <= 12'h0;
			first_done <= 1'b0;
		end else begin
			if (conv_end && cur_is_sw) begin
				single_result <= conv_stat.code;
				first_done <= 1'b1;
			end
			if (per_end) begin
				slot_result[cur_dest] <= conv_stat.code;
			end
		end
	end

	// Register writes, byte lane 0 only
	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			ctrl1 <= `HKA_RST_BYTE;
			rt_ctrl <= `HKA_RST_BYTE;
			single_chan <= 4'h0;
			per_sel <= `HKA_RST_BYTE;
			per_ctrl <= `HKA_RST_BYTE;
		end else if (bus_wr) begin
			if (hit_ctrl1) begin
				ctrl1 <= {5'h0, dat_i[2:0]};
			end else if (hit_rt) begin
				rt_ctrl <= {7'h0, dat_i[0]};
			end else if (hit_ssel) begin
				single_chan <= dat_i[3:0];
			end else if (hit_psel) begin
				per_sel <= dat_i[7:0];
			end else if (hit_pctrl) begin
				per_ctrl <= {1'b0, dat_i[6:0]};
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_thr
			always_ff @(posedge sys_clk or negedge rst_sync) begin
				if (!rst_sync) begin
					thr_low[g] <= `HKA_RST_BYTE;
					thr_high[g] <= `HKA_RST_BYTE;
				end else if (bus_wr && hit_thr_low[g]) begin
					thr_low[g] <= dat_i[7:0];
				end else if (bus_wr && hit_thr_high[g]) begin
					thr_high[g] <= {dat_i[7], 3'h0, dat_i[3:0]};
				end
			end
		end
	endgenerate

	// Read mux; unmapped offsets read zero and still acknowledge
	wire [7:0] status = {5'h0, first_done, sw_pend, !idle};
	logic [7:0] rd_byte;
	always_comb begin
		if (adr_i == `HKA_OFF_CTRL1) begin
			rd_byte = ctrl1;
		end else if (adr_i == `HKA_OFF_RT_CTRL) begin
			rd_byte = rt_ctrl;
		end else if (adr_i == `HKA_OFF_SINGLE_SEL) begin
			rd_byte = {sw_pend, 3'h0, single_chan};
		end else if (adr_i == `HKA_OFF_SINGLE_LOW) begin
			rd_byte = single_result[7:0];
		end else if (adr_i == `HKA_OFF_SINGLE_HIGH) begin
			rd_byte = {4'h0, single_result[11:8]};
		end else if (adr_i == `HKA_OFF_PER_SEL) begin
			rd_byte = per_sel;
		end else if (adr_i == `HKA_OFF_THR0_LOW) begin
			rd_byte = thr_low[0];
		end else if (adr_i == `HKA_OFF_THR0_HIGH) begin
			rd_byte = thr_high[0];
		end else if (adr_i == `HKA_OFF_THR1_LOW) begin
			rd_byte = thr_low[1];
		end else if (adr_i == `HKA_OFF_THR1_HIGH) begin
			rd_byte = thr_high[1];
		end else if (adr_i == `HKA_OFF_PER_CTRL) begin
			rd_byte = per_ctrl;
		end else if (adr_i == `HKA_OFF_RES0_LOW) begin
			rd_byte = slot_result[0][7:0];
		end else if (adr_i == `HKA_OFF_RES0_HIGH) begin
			rd_byte = {4'h0, slot_result[0][11:8]};
		end else if (adr_i == `HKA_OFF_RES1_LOW) begin
			rd_byte = slot_result[1][7:0];
		end else if (adr_i == `HKA_OFF_RES1_HIGH) begin
			rd_byte = {4'h0, slot_result[1][11:8]};
		end else if (adr_i == `HKA_OFF_STATUS) begin
			rd_byte = status;
		end else if (adr_i == `HKA_OFF_TRIM1) begin
			rd_byte = factory_deviation_one;
		end else if (adr_i == `HKA_OFF_TRIM2) begin
			rd_byte = factory_deviation_two;
		end else begin
			rd_byte = 8'h00;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= bus_req;
			if (bus_req && !we_i) begin
				dat_o <= {24'h0, rd_byte};
			end
		end
	end
endmodule : hka_adc_sequencer

//--- verification/hka_conv_model.sv
`timescale 1ns/100ps
module hka_conv_model (
	input wire logic sys_clk,
	input wire hka_adc_pkg::hka_conv_ctrl_t conv_ctrl,
	input wire logic [11:0] base_code,
	input wire logic [7:0] latency,
	output hka_adc_pkg::hka_conv_stat_t conv_stat
);
	import hka_adc_pkg::*;
	logic busy = 1'b0;
	logic [7:0] cnt = 8'h00;
	logic [11:0] junk = 12'h5a5;
	initial conv_stat = '0;
	// Code is garbage outside done so nothing leans on a stale value
	always @(posedge sys_clk) begin
		junk <= ~junk;
		conv_stat.done <= 1'b0;
		conv_stat.code <= junk;
		if (conv_ctrl.sample) begin
			busy <= 1'b1;
			cnt <= latency;
		end else if (busy && cnt == 8'h00 && conv_ctrl.power_on) begin
			busy <= 1'b0;
			conv_stat.done <= 1'b1;
			conv_stat.code <= base_code + 12'(conv_ctrl.channel);
		end else if (busy) begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule : hka_conv_model

//--- verification/hka_adc_sequencer_props.sv
`timescale 1ns/100ps
module hka_adc_props #(
	parameter int unsigned EXT_DELAY_CYC = 8000,
	parameter int unsigned INTERVAL_BASE_CYC = 20000
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire hka_adc_pkg::hka_conv_ctrl_t conv_ctrl,
	input wire hka_adc_pkg::hka_conv_stat_t conv_stat,
	input wire hka_adc_pkg::hka_power_state_t power_state,
	input wire logic thermal_sensor_en,
	input wire logic [7:0] factory_deviation_one,
	input wire logic [7:0] factory_deviation_two,
	input wire logic conv_event,
	input wire logic threshold_event,
	input wire logic shutdown_req
);
	import hka_adc_pkg::*;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	ref_follow_a: assert property (
		conv_ctrl.reference_on == conv_ctrl.power_on)
		else $error("reference off while powered");
	done_event_a: assert property (conv_stat.done |=> conv_event)
		else $error("no event after done");
	sample_power_a: assert property (
		conv_ctrl.sample |-> conv_ctrl.power_on ##1 !conv_ctrl.sample)
		else $error("sample unpowered or long");
	thr_event_a: assert property (threshold_event |-> conv_event)
		else $error("crossing without result");
	shut_thr_a: assert property (shutdown_req |-> threshold_event)
		else $error("shutdown without crossing");
	sleep_chan_a: assert property (
		$rose(conv_ctrl.power_on) && power_state != HKA_PS_ACTIVE
		|-> conv_ctrl.channel <= 4'd10 || (power_state == HKA_PS_SLEEP
		&& thermal_sensor_en && conv_ctrl.channel inside {12, 13}))
		else $error("channel converted in low power");
	legal_chan_a: assert property ($rose(conv_ctrl.power_on) |->
		conv_ctrl.channel inside {0, 1, 2, 7, 10, 11, 12, 13, 15})
		else $error("unusable channel converted");
endmodule : hka_adc_props
bind hka_adc_sequencer hka_adc_props #(
	.EXT_DELAY_CYC(EXT_DELAY_CYC),
	.INTERVAL_BASE_CYC(INTERVAL_BASE_CYC)
) hka_adc_props_i (
	.sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o), .conv_ctrl(conv_ctrl),
	.conv_stat(conv_stat), .power_state(power_state),
	.thermal_sensor_en(thermal_sensor_en),
	.factory_deviation_one(factory_deviation_one),
	.factory_deviation_two(factory_deviation_two),
	.conv_event(conv_event), .threshold_event(threshold_event),
	.shutdown_req(shutdown_req)
);

//--- verification/test_adc_conversion_sequencer.sv
`timescale 1ns/100ps
module test_adc_conversion_sequencer;
	import hka_adc_pkg::*;
	localparam int unsigned EXT = 5;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	hka_conv_ctrl_t conv_ctrl;
	hka_conv_stat_t conv_stat;
	hka_power_state_t power_state = HKA_PS_ACTIVE;
	logic therm = 1'b1;
	logic [7:0] dev_one = 8'h00;
	logic [7:0] dev_two = 8'h00;
	logic conv_event;
	logic threshold_event;
	logic shutdown_req;
	logic [11:0] base_code = 12'h000;
	logic [7:0] latency = 8'h00;
	logic [31:0] rd;
	logic [3:0] c;
	logic [3:0] chans [9] = '{0, 1, 2, 7, 10, 11, 12, 13, 15};
	int n_fail = 0;
	int samples_checked = 0;
	int span;
	int span0;
	int n_thr = 0;
	int n_sd = 0;
	int k;
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		n_thr <= n_thr + int'(threshold_event === 1'b1);
		n_sd <= n_sd + int'(shutdown_req === 1'b1);
	end
	hka_adc_sequencer #(.EXT_DELAY_CYC(EXT), .INTERVAL_BASE_CYC(50))
	hka_adc_sequencer_i (.sys_clk(sys_clk), .rst_b(rst_b), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conv_ctrl(conv_ctrl),
		.conv_stat(conv_stat), .power_state(power_state),
		.thermal_sensor_en(therm), .factory_deviation_one(dev_one),
		.factory_deviation_two(dev_two), .conv_event(conv_event),
		.threshold_event(threshold_event), .shutdown_req(shutdown_req));
	hka_conv_model hka_conv_model_i (.sys_clk(sys_clk),
		.conv_ctrl(conv_ctrl), .base_code(base_code), .latency(latency),
		.conv_stat(conv_stat));
	task finish_test;
		$display("checked %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task tmo;
		n_fail++;
		$display("MISMATCH at %0t: %h %h (timeout)", $time, 0, 1);
		finish_test();
	endtask : tmo
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %h %h", $time, seen, exp);
		end
	endtask : chk
	// Partner model answers with its base code plus the channel number
	function automatic logic [11:0] exp_code(input logic [11:0] b,
		input logic [3:0] ch);
		exp_code = b + 12'(ch);
	endfunction : exp_code
	// Request held until ack is sampled, then dropped for a cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge sys_clk);
		{cyc_i, stb_i, we_i} <= {2'b11, w};
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge sys_clk);
			i++;
		end while (ack_o !== 1'b1 && i < 20);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (ack_o !== 1'b1) tmo();
	endtask : wb
	task wait_samp(output logic [3:0] ch);
		span = 0;
		do begin
			@(posedge sys_clk);
			span++;
		end while (conv_ctrl.sample !== 1'b1 && span < 400);
		ch = conv_ctrl.channel;
		if (conv_ctrl.sample !== 1'b1) tmo();
	endtask : wait_samp
	task rd12(input logic [7:0] a, input logic [11:0] e);
		wb(0, a, 0);
		chk(rd, 32'(e[7:0]));
		wb(0, a + 8'h04, 0);
		chk(rd, 32'(e[11:8]));
	endtask : rd12
	// Mode 0 expects no power-up within 80 cycles, 2 skips the result check
	task single(input logic [3:0] ch, input int mode);
		logic [3:0] s;
		int i;
		wb(1, 8'h08, 32'(ch));
		wb(1, 8'h08, {24'h0, 4'h8, ch});
		if (mode == 0) begin
			i = 0;
			repeat (80) begin
				@(posedge sys_clk);
				i += int'(conv_ctrl.power_on === 1'b1);
			end
			chk(i, 0);
		end else begin
			wait_samp(s);
			chk(32'(s), 32'(ch));
			i = 0;
			do begin
				@(posedge sys_clk);
				i++;
			end while (conv_event !== 1'b1 && i < 300);
			if (conv_event !== 1'b1) tmo();
			if (mode == 1) rd12(8'h0c, exp_code(base_code, ch));
		end
	endtask : single
	initial begin
		void'($urandom(32'hd5e8));
		dev_one = 8'($urandom);
		dev_two = 8'($urandom);
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		wb(0, 8'h3c, 0);
		chk(rd, 0);
		wb(1, 8'h40, 32'hff);
		wb(0, 8'h40, 0);
		chk(rd, 32'(dev_one));
		wb(0, 8'h44, 0);
		chk(rd, 32'(dev_two));
		wb(1, 8'h80, 32'h5a);
		wb(0, 8'h80, 0);
		chk(rd, 0);
		for (k = 0; k < 4; k++) begin
			wb(1, 8'h00, 32'(k) << 1);
			// Bias output is registered from the control byte
			@(posedge sys_clk);
			chk(32'(conv_ctrl.bias_sel), 32'(k));
		end
		$display("registers done");
		single(4'd1, 2);
		for (k = 0; k < 9; k++) begin
			base_code <= k == 0 ? 12'h0 : k == 1 ? 12'hffe : 12'($urandom);
			latency <= 8'($urandom % 41);
			single(chans[k], 1);
		end
		span0 = span;
		single(4'd3, 0);
		wb(1, 8'h04, 32'h1);
		single(4'd2, 1);
		chk(span, span0 + EXT);
		wb(1, 8'h04, 32'h0);
		$display("single conversions done");
		power_state <= HKA_PS_SLEEP;
		single(4'd11, 0);
		single(4'd12, 1);
		therm <= 1'b0;
		single(4'd13, 0);
		single(4'd10, 1);
		power_state <= HKA_PS_OFF;
		therm <= 1'b1;
		single(4'd12, 0);
		power_state <= HKA_PS_ACTIVE;
		$display("low power limits done");
		base_code <= 12'($urandom % 4000);
		latency <= 8'd5;
		wb(1, 8'h14, 32'h17);
		wb(1, 8'h1c, 32'h80);
		wb(1, 8'h20, 32'hff);
		wb(1, 8'h24, 32'h0f);
		wb(1, 8'h28, 32'h23);
		wait_samp(c);
		chk(32'(c), 32'd1);
		wait_samp(c);
		chk(32'(c), 32'd7);
		base_code <= 12'($urandom % 4000);
		latency <= 8'd60;
		k = 0;
		do begin
			wait_samp(c);
			k++;
		end while (c !== 4'd7 && k < 6);
		wb(1, 8'h08, 32'h02);
		wb(1, 8'h08, 32'h82);
		wait_samp(c);
		chk(32'(c), 32'd2);
		wait_samp(c);
		chk(32'(c), 32'd1);
		wb(1, 8'h00, 32'h1);
		wb(1, 8'h28, 32'h0);
		repeat (2000) @(posedge sys_clk);
		wb(1, 8'h00, 32'h0);
		rd12(8'h2c, exp_code(base_code, 4'd1));
		rd12(8'h34, exp_code(base_code, 4'd7));
		rd12(8'h0c, exp_code(base_code, 4'd2));
		chk(32'(n_sd > 0 && n_sd < n_thr), 32'd1);
		$display("periodic conversions done");
		finish_test();
	end
endmodule : test_adc_conversion_sequencer
